// *** hw/sdsl_pkg.sv ***
// shared constants for the stall detect and stop logic
// assumes a single 125 MHz clock and a plain register port with 8-bit byte addresses
package sdsl_pkg;

  localparam int unsigned CLK_MHZ      = 125;
  localparam int unsigned RESULT_W     = 10;
  localparam int unsigned SGT_W        = 7;
  localparam int unsigned VLIM_W       = 20;
  localparam int unsigned VEL_W        = 23;
  localparam int unsigned WAIT_W       = 16;
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned AVG_DEPTH    = 4;
  localparam int unsigned AVG_SHIFT    = 2;
  localparam int unsigned SGT_SCALE_SH = 4;

  localparam logic [9:0]  RESULT_MAX   = 10'h3ff;

  // register byte addresses
  localparam logic [7:0] ADDR_SWITCH_MODE = 8'h00;
  localparam logic [7:0] ADDR_THRESHOLD   = 8'h04;
  localparam logic [7:0] ADDR_LOWER_VEL   = 8'h08;
  localparam logic [7:0] ADDR_UPPER_VEL   = 8'h0c;
  localparam logic [7:0] ADDR_ZERO_WAIT   = 8'h10;
  localparam logic [7:0] ADDR_RAMP_STATUS = 8'h14;
  localparam logic [7:0] ADDR_DRIVER_STATUS_REG  = 8'h18;
  localparam logic [7:0] ADDR_ACT_VEL     = 8'h1c;

  // field positions
  localparam int unsigned SWM_STOP_BIT    = 0;
  localparam int unsigned SWM_FILT_BIT    = 1;
  localparam int unsigned RS_EVENT_BIT    = 0;
  localparam int unsigned RS_HALT_BIT     = 1;
  localparam int unsigned DS_STALL_BIT    = 24;

  // reset values
  localparam logic [6:0]  RST_THRESHOLD   = 7'h00;
  localparam logic [19:0] RST_LOWER_VEL   = 20'h00000;
  localparam logic [19:0] RST_UPPER_VEL   = 20'h00000;
  localparam logic [15:0] RST_ZERO_WAIT   = 16'h0000;

  typedef enum logic [2:0] {
    SDSL_RUN  = 3'b001,
    SDSL_STOP = 3'b010,
    SDSL_WAIT = 3'b100
  } sdsl_ramp_e;

endpackage : sdsl_pkg

// *** hw/sdsl_avg4.sv ***
// load result stage: passes or averages the per-step measurement
// assumes meas_vld is a one-cycle pulse per full step on the same clock
`timescale 1ns/1ps
module sdsl_avg4 (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       filter_en,
  input  wire logic       meas_vld,
  input  wire logic [9:0] meas,
  output logic            res_vld,
  output logic [9:0]      res
);

  typedef struct packed {
    logic [11:0] acc;
    logic [1:0]  cnt;
    logic [9:0]  res;
    logic        vld;
  } sdsl_avg_s;

  sdsl_avg_s s_ff;
  sdsl_avg_s nxt_s;
  logic [11:0] sum;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.vld = 1'b0;
    sum = s_ff.acc + {2'b00, meas};
    if (meas_vld) begin
      if (!filter_en) begin
        // R2 one result per full step
        nxt_s.res = meas;
        nxt_s.vld = 1'b1;
        nxt_s.acc = 12'h000;
        nxt_s.cnt = 2'h0;
      end else if (s_ff.cnt == 2'(sdsl_pkg::AVG_DEPTH - 1)) begin
        // R3 mean of four readings
        nxt_s.res = sum[11:sdsl_pkg::AVG_SHIFT];
        nxt_s.vld = 1'b1;
        nxt_s.acc = 12'h000;
        nxt_s.cnt = 2'h0;
      end else begin
        nxt_s.acc = sum;
        nxt_s.cnt = s_ff.cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign res_vld = s_ff.vld;
  assign res     = s_ff.res;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_UNFILT_PER_STEP: assert property (meas_vld && !filter_en |=> res_vld && res == $past(meas)) // R2
    else $error("unfiltered result not produced for a full step");
  AST_FILT_FOURTH: assert property (meas_vld && filter_en && s_ff.cnt != 2'h3 |=> !res_vld) // R3
    else $error("filtered result produced before four readings");
  AST_FILT_MEAN: assert property (meas_vld && filter_en && s_ff.cnt == 2'h3 |=> res_vld && res == $past(sum[11:2])) // R3
    else $error("filtered result is not the mean of four readings");

endmodule : sdsl_avg4

// *** hw/sdsl_stall_top.sv ***
// stall detection and stop-on-stall for the ramp generator
// assumes full_step, raw_load, step_period and vel_cmd come from logic on the same clock
// Behaviour
// R1 - stall detection is off while the velocity is below the lower or above the upper limit.
// R2 - with the filter bit clear a new load result is made for every completed full step.
// R3 - with the filter bit set the load result is the mean of four consecutive readings.
// R4 - with stop-on-stall enabled a stall halts the ramp and forces actual velocity to zero.
// R5 - a stall-induced stop sets the stall flag in the driver status register.
// R6 - reading ramp status clears the stall event; the motor restarts after the standstill wait, as does disabling stop-on-stall.
// R7 - a load result of zero counts as a stall and stops the motor when stop-on-stall is enabled.
// R8 - software should keep the filter off for best stall detection.
// R9 - the load result is unsigned 0 to 1023, zero meaning highest load.
// R10 - the threshold is signed; positive values lower sensitivity, negative raise it, zero is neutral.
// R11 - the stall condition is only checked when a new result arrives and the window allows it.
`timescale 1ns/1ps
module sdsl_stall_top (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic [31:0]      rd_data,
  input  wire logic        full_step,
  input  wire logic [9:0]  raw_load,
  input  wire logic [19:0] step_period,
  input  wire logic [22:0] vel_cmd,
  output logic [22:0]      actual_velocity,
  output logic [9:0]       load_measure_result,
  output logic             motion_halted
);

  typedef struct packed {
    sdsl_pkg::sdsl_ramp_e st;
    logic                 stop_en;
    logic                 filt_en;
    logic [6:0]           stall_threshold;
    logic [19:0]          lo;
    logic [19:0]          hi;
    logic [15:0]          zwait;
    logic [15:0]          wcnt;
    logic                 event_f;
    logic [22:0]          vact;
    logic [31:0]          rdata;
  } sdsl_state_s;

  sdsl_state_s s_ff;
  sdsl_state_s nxt_s;

  logic        res_vld;
  logic [9:0]  res;
  logic [11:0] adj;
  logic [9:0]  meas;
  logic        win_ok;
  logic        stall_hit;
  logic        rd_ramp;

  ////////////////////////////////////////////////////////////////////////////
  // measurement shaping

  // R10 signed threshold offsets the reading
  assign adj = 12'($signed({2'b00, raw_load}) + ($signed({{5{s_ff.stall_threshold[6]}}, s_ff.stall_threshold}) <<< sdsl_pkg::SGT_SCALE_SH));

  // R9 saturate to 0..1023
  always_comb begin
    if (adj[11]) begin
      meas = 10'h000;
    end else if (adj[10]) begin
      meas = sdsl_pkg::RESULT_MAX;
    end else begin
      meas = adj[9:0];
    end
  end

  sdsl_avg4 u_avg (
    .clock     (clock),
    .rst_n     (rst_n),
    .filter_en (s_ff.filt_en),
    .meas_vld  (full_step),
    .meas      (meas),
    .res_vld   (res_vld),
    .res       (res)
  );

  // R1 window in step period terms: short period is fast
  assign win_ok = (step_period <= s_ff.lo) && (step_period >= s_ff.hi);

  // R11 evaluate only on a fresh result inside the window
  // R7 zero reading means stall
  assign stall_hit = res_vld && win_ok && (res == 10'h000) && s_ff.stop_en;

  assign rd_ramp = rd_en && (addr == sdsl_pkg::ADDR_RAMP_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_s = s_ff;
    nxt_s.rdata = 32'h0000_0000;

    if (wr_en) begin
      case (addr)
        sdsl_pkg::ADDR_SWITCH_MODE: begin
          nxt_s.stop_en = wr_data[sdsl_pkg::SWM_STOP_BIT];
          nxt_s.filt_en = wr_data[sdsl_pkg::SWM_FILT_BIT];
        end
        sdsl_pkg::ADDR_THRESHOLD: nxt_s.stall_threshold = wr_data[6:0];
        sdsl_pkg::ADDR_LOWER_VEL: nxt_s.lo = wr_data[19:0];
        sdsl_pkg::ADDR_UPPER_VEL: nxt_s.hi = wr_data[19:0];
        sdsl_pkg::ADDR_ZERO_WAIT: nxt_s.zwait = wr_data[15:0];
        default: ;
      endcase
    end

    if (rd_en) begin
      case (addr)
        sdsl_pkg::ADDR_SWITCH_MODE: begin
          nxt_s.rdata[sdsl_pkg::SWM_STOP_BIT] = s_ff.stop_en;
          nxt_s.rdata[sdsl_pkg::SWM_FILT_BIT] = s_ff.filt_en;
        end
        sdsl_pkg::ADDR_THRESHOLD: nxt_s.rdata[6:0] = s_ff.stall_threshold;
        sdsl_pkg::ADDR_LOWER_VEL: nxt_s.rdata[19:0] = s_ff.lo;
        sdsl_pkg::ADDR_UPPER_VEL: nxt_s.rdata[19:0] = s_ff.hi;
        sdsl_pkg::ADDR_ZERO_WAIT: nxt_s.rdata[15:0] = s_ff.zwait;
        sdsl_pkg::ADDR_RAMP_STATUS: begin
          nxt_s.rdata[sdsl_pkg::RS_EVENT_BIT] = s_ff.event_f;
          nxt_s.rdata[sdsl_pkg::RS_HALT_BIT]  = (s_ff.st != sdsl_pkg::SDSL_RUN);
        end
        sdsl_pkg::ADDR_DRIVER_STATUS_REG: begin
          nxt_s.rdata[9:0] = res;
          nxt_s.rdata[sdsl_pkg::DS_STALL_BIT] = (s_ff.st != sdsl_pkg::SDSL_RUN);
        end
        sdsl_pkg::ADDR_ACT_VEL: nxt_s.rdata[22:0] = s_ff.vact;
        default: ;
      endcase
    end

    // R6 read clears the event
    if (rd_ramp) begin
      nxt_s.event_f = 1'b0;
    end

    case (s_ff.st)
      sdsl_pkg::SDSL_RUN: begin
        // R4 halt on stall, set beats clear
        if (stall_hit) begin
          nxt_s.st      = sdsl_pkg::SDSL_STOP;
          nxt_s.event_f = 1'b1;
        end
      end
      sdsl_pkg::SDSL_STOP: begin
        // R6 release by clear or by disabling the stop
        if (!s_ff.event_f || !s_ff.stop_en) begin
          nxt_s.st   = sdsl_pkg::SDSL_WAIT;
          nxt_s.wcnt = 16'h0000;
        end
      end
      sdsl_pkg::SDSL_WAIT: begin
        // R6 standstill wait before restart
        if (s_ff.wcnt >= s_ff.zwait) begin
          nxt_s.st = sdsl_pkg::SDSL_RUN;
        end else begin
          nxt_s.wcnt = s_ff.wcnt + 16'h0001;
        end
      end
      default: nxt_s.st = sdsl_pkg::SDSL_RUN;
    endcase

    // R4 velocity forced to zero while halted
    nxt_s.vact = (nxt_s.st == sdsl_pkg::SDSL_RUN) ? vel_cmd : 23'h000000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_ff.st      <= sdsl_pkg::SDSL_RUN;
      s_ff.stop_en <= 1'b0;
      s_ff.filt_en <= 1'b0;
      s_ff.stall_threshold     <= sdsl_pkg::RST_THRESHOLD;
      s_ff.lo      <= sdsl_pkg::RST_LOWER_VEL;
      s_ff.hi      <= sdsl_pkg::RST_UPPER_VEL;
      s_ff.zwait   <= sdsl_pkg::RST_ZERO_WAIT;
      s_ff.wcnt    <= 16'h0000;
      s_ff.event_f <= 1'b0;
      s_ff.vact    <= 23'h000000;
      s_ff.rdata   <= 32'h0000_0000;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rd_data             = s_ff.rdata;
  assign actual_velocity     = s_ff.vact;
  assign load_measure_result = res;
  // R5 stall flag follows the halted state
  assign motion_halted       = (s_ff.st != sdsl_pkg::SDSL_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence seq_running_stall;
    s_ff.st == sdsl_pkg::SDSL_RUN && stall_hit;
  endsequence

  sequence seq_halted_zero;
    s_ff.st == sdsl_pkg::SDSL_STOP && actual_velocity == 23'h000000 && s_ff.event_f;
  endsequence

  AST_WINDOW_GATE: assert property (s_ff.st == sdsl_pkg::SDSL_RUN && !win_ok |=> s_ff.st == sdsl_pkg::SDSL_RUN) // R1
    else $error("stop taken outside the velocity window");
  AST_STOP_ZERO: assert property (seq_running_stall |=> seq_halted_zero) // R4
    else $error("stall did not halt with zero velocity");
  AST_HALT_VEL: assert property (motion_halted |-> actual_velocity == 23'h000000) // R4
    else $error("velocity nonzero while halted");
  AST_STALL_FLAG: assert property ($rose(s_ff.event_f) |-> motion_halted && $past(res == 10'h000)) // R5
    else $error("stall flag missing on stop");
  AST_READ_CLEAR: assert property (seq_halted_zero ##0 rd_ramp |=> !s_ff.event_f ##1 s_ff.st == sdsl_pkg::SDSL_WAIT) // R6
    else $error("ramp status read did not release the stop");
  AST_DISABLE_RELEASE: assert property (s_ff.st == sdsl_pkg::SDSL_STOP && !s_ff.stop_en |=> s_ff.st == sdsl_pkg::SDSL_WAIT) // R6
    else $error("disabling stop-on-stall did not release");
  AST_WAIT_END: assert property (s_ff.st == sdsl_pkg::SDSL_WAIT && s_ff.wcnt >= s_ff.zwait |=> actual_velocity == $past(vel_cmd)) // R6
    else $error("no restart after standstill wait");
  AST_WAIT_HOLD: assert property (s_ff.st == sdsl_pkg::SDSL_WAIT && s_ff.wcnt < s_ff.zwait |=> motion_halted) // R6
    else $error("restart before standstill wait expired");
  AST_ZERO_ONLY: assert property (res_vld && res != 10'h000 && s_ff.st == sdsl_pkg::SDSL_RUN |=> !motion_halted) // R7
    else $error("stop on a nonzero reading");
  AST_NO_STOP_DISABLED: assert property (!s_ff.stop_en && s_ff.st == sdsl_pkg::SDSL_RUN |=> !motion_halted) // R7
    else $error("stop while stop-on-stall disabled");
  AST_SATURATE: assert property (adj[11] |-> meas == 10'h000) // R9
    else $error("negative reading not clamped to zero");
  AST_FRESH_ONLY: assert property (!res_vld && s_ff.st == sdsl_pkg::SDSL_RUN |=> s_ff.st == sdsl_pkg::SDSL_RUN) // R11
    else $error("stall evaluated without a new result");

endmodule : sdsl_stall_top

// *** tb/sdsl_load_src.sv ***
// load source standing in for the motor and power stage
// assumes the bench calls step while the clock runs
`timescale 1ns/1ps
module sdsl_load_src (
  input  wire logic  clock,
  output logic       full_step,
  output logic [9:0] raw_load
);
  initial begin
    full_step = 1'b0;
    raw_load  = 10'h155;
  end
  // slow or prompt: gap idle cycles before the step
  task automatic step(input logic [9:0] v, input int gap);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    full_step <= 1'b1;
    raw_load  <= v;
    @(posedge clock);
    full_step <= 1'b0;
    // a stale reading must never look valid
    raw_load  <= ~v;
  endtask : step
endmodule : sdsl_load_src

// *** tb/sdsl_stall_top_tb.sv ***
// self-checking bench for the stall detect and stop logic
// assumes one 125 MHz clock and the load source model beside it
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; $display("ERROR %0t got %h exp %h", $time, a, e); end end
module sdsl_stall_top_tb;
  logic        clock, rst_n, wr_en, rd_en, rd_p1, full_step, motion_halted;
  logic [7:0]  addr;
  logic [31:0] wr_data, seed, rd_data, e;
  logic [19:0] step_period;
  logic [22:0] vel_cmd, actual_velocity;
  logic [9:0]  load_measure_result, raw_load, v;
  logic [31:0] exp_q[$];
  int          n_fail, n_compared, n;

  sdsl_stall_top sdsl_stall_top_inst (.clock(clock), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .full_step(full_step), .raw_load(raw_load),
    .step_period(step_period), .vel_cmd(vel_cmd), .actual_velocity(actual_velocity),
    .load_measure_result(load_measure_result), .motion_halted(motion_halted));
  sdsl_load_src sdsl_load_src_inst (.clock(clock), .full_step(full_step), .raw_load(raw_load));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge clock);
    wr_en   <= 1'b0;
  endtask : wr

  // expectation noted now, judged by the watcher
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge clock);
    rd_en <= 1'b1;
    addr  <= a;
    exp_q.push_back(x);
    @(posedge clock);
    rd_en <= 1'b0;
  endtask : rd

  task automatic stp(input logic [9:0] r);
    sdsl_load_src_inst.step(r, int'(xs() % 3));
    repeat (2) @(posedge clock);
    #1;
  endtask : stp

  task automatic wait_run(input int lo, input int hi);
    n = 0;
    while (motion_halted !== 1'b0 && n < hi) begin
      @(posedge clock);
      n++;
    end
    #1;
    `CHK(n >= lo && n < hi, 1'b1)
    if (n >= hi) give_verdict();
  endtask : wait_run

  task automatic give_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    rd_p1 <= rd_en;
    if (rd_p1 === 1'b1) begin
      e = exp_q.pop_front();
      `CHK(rd_data, e)
    end
  end

  initial begin
    {rst_n, wr_en, rd_en, rd_p1, addr, wr_data} = '0;
    n_fail = 0;
    n_compared = 0;
    seed = 32'd54228;
    step_period = 20'h00032;
    vel_cmd = 23'(xs());
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    // reset values, unmapped place reads zero
    // actual velocity follows the command while running
    for (int a = 0; a <= 32; a += 4) rd(8'(a), (a == 28) ? {9'h000, vel_cmd} : 32'h0);
    wr(8'h1c, 32'hffffffff);
    rd(8'h1c, {9'h000, vel_cmd});
    wr(8'h08, 32'h64);
    wr(8'h0c, 32'h0a);
    wr(8'h10, 32'h20);
    wr(8'h00, 32'h1);
    rd(8'h08, 32'h64);
    rd(8'h10, 32'h20);
    $display("test regs done");
    // zero reading outside the window on both sides
    step_period <= 20'h000c8;
    stp(10'h0);
    `CHK(motion_halted, 1'b0)
    step_period <= 20'h00005;
    stp(10'h0);
    `CHK(motion_halted, 1'b0)
    step_period <= 20'h00032;
    repeat (4) begin
      v = 10'(xs() % 1000 + 20);
      stp(v);
      `CHK(load_measure_result, v)
      `CHK(actual_velocity, vel_cmd)
    end
    wr(8'h04, 32'h7f);
    stp(10'd20);
    `CHK(load_measure_result, 10'd4)
    wr(8'h04, 32'h1);
    stp(10'd1020);
    `CHK(load_measure_result, 10'h3ff)
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h3);
    for (int i = 1; i <= 4; i++) begin
      stp(10'(i * 10));
      `CHK(load_measure_result, i < 4 ? 10'h3ff : 10'd25)
    end
    wr(8'h00, 32'h1);
    $display("test measure done");
    stp(10'h0);
    `CHK(motion_halted, 1'b1)
    `CHK(actual_velocity, 23'h0)
    rd(8'h18, 32'h01000000);
    rd(8'h14, 32'h3);
    rd(8'h14, 32'h2);
    wait_run(24, 40);
    @(posedge clock);
    #1;
    `CHK(actual_velocity, vel_cmd)
    $display("test stall done");
    stp(10'h0);
    `CHK(motion_halted, 1'b1)
    wr(8'h00, 32'h0);
    // release still passes the standstill wait
    wait_run(24, 40);
    rd(8'h14, 32'h1);
    repeat (3) @(posedge clock);
    $display("test release done");
    give_verdict();
  end
endmodule : sdsl_stall_top_tb
